//--- src/dcc_consts.svh
// Summary of operation
// - The host-to-card beat counter is 42 bits, counts each valid read beat while monitoring and the channel both run, low word at 0xCC and bits 41:32 at 0xD0.
// - Bit 16 of the upper beat-count word is a read-only flag that sets once the counter reaches all ones.
// - The beat counter clears only through the monitor clear and auto controls, never by writes to the count words.
// - The identity word is read-only with subsystem code, target code, channel number and version in their fields.
// - Identity bit 15 reads 1 for a streaming user interface and 0 for memory-mapped.
// - Control bit 27 suppresses metadata writeback on a streaming channel and does nothing on a memory-mapped one.
// - Control bit 26 makes the channel write back the completed descriptor count on each completed descriptor carrying the completed flag, except at a run rise.
// - An all-ones descriptor-error enable field logs descriptor errors and stops the engine on one.
// - An all-ones read-error enable field logs read errors and stops the engine on one.
// - Each enable in control bits 6 to 1 lets its matching status condition be logged.
// - Control bit 0 starts the engine; clearing it stops the engine after the descriptor in progress.
// - A condition is logged only when enabled, and raises the interrupt only when its mask bit is also set.
// - Setting the run bit clears the logged status conditions.
// - The completed descriptor count clears on each rising edge of run and counts every completed descriptor except one finishing on that edge.
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

`define DCC_OFS_IDENT 8'h00
`define DCC_OFS_CTRL 8'h04
`define DCC_OFS_CTRL_SET 8'h08
`define DCC_OFS_CTRL_CLR 8'h0C
`define DCC_OFS_STAT 8'h40
`define DCC_OFS_STAT_RC 8'h44
`define DCC_OFS_DONE_CNT 8'h48
`define DCC_OFS_ALIGN 8'h4C
`define DCC_OFS_WB_LO 8'h88
`define DCC_OFS_WB_HI 8'h8C
`define DCC_OFS_MASK 8'h90
`define DCC_OFS_MASK_SET 8'h94
`define DCC_OFS_MASK_CLR 8'h98
`define DCC_OFS_PMON 8'hC0
`define DCC_OFS_CYC_LO 8'hC4
`define DCC_OFS_CYC_HI 8'hC8
`define DCC_OFS_BEAT_LO 8'hCC
`define DCC_OFS_BEAT_HI 8'hD0

`define DCC_CTRL_WMASK 32'h0EF83E7F
`define DCC_STAT_WMASK 32'h00F83E7E
`define DCC_CTRL_RESET 32'h00000000
`define DCC_STAT_RESET 32'h00000000
`define DCC_MASK_RESET 32'h00000000

`define DCC_BIT_RUN 0
`define DCC_BIT_DESC_HALT 1
`define DCC_BIT_DESC_DONE 2
`define DCC_BIT_MISALIGN 3
`define DCC_BIT_BAD_SIG 4
`define DCC_BIT_BAD_LEN 5
`define DCC_BIT_IDLE_HALT 6
`define DCC_BIT_NON_INC 25
`define DCC_BIT_WB_ON 26
`define DCC_BIT_NO_META 27
`define DCC_RD_ERR_LSB 9
`define DCC_DESC_ERR_LSB 19
`define DCC_ERR_ALL 5'h1F
`define DCC_BIT_STREAM 15
`define DCC_BIT_MAXED 16

`define DCC_PM_AUTO 0
`define DCC_PM_CLEAR 1
`define DCC_PM_RUN 2

`define DCC_CNT_W 42
`define DCC_CNT_MAX 42'h3FFFFFFFFFF

`endif

//--- src/dcc_pkg.sv
package dcc_pkg;

	// Conditions reported by the engine, one-cycle pulses except busy.
	typedef struct packed {
		logic busy;
		logic desc_done;
		logic desc_done_flag;
		logic desc_stop_flag;
		logic [4:0] desc_error;
		logic [4:0] read_error;
		logic bad_length;
		logic bad_signature;
		logic misalignment;
		logic read_beat_valid;
	} dcc_engine_evt_s;

	// Controls handed to the engine and its movers.
	typedef struct packed {
		logic run;
		logic fault_halt;
		logic meta_writeback_off;
		logic fixed_read_addr;
		logic completion_writeback_on;
		logic [63:0] writeback_addr;
	} dcc_engine_ctl_s;

	// Completed-count writeback request.
	typedef struct packed {
		logic valid;
		logic [31:0] count;
	} dcc_writeback_s;

	typedef enum logic [2:0] {
		DCC_ST_IDLE = 3'b001,
		DCC_ST_RUN = 3'b010,
		DCC_ST_DRAIN = 3'b100
	} dcc_run_state_e;

endpackage

//--- src/dcc_channel_regs.sv
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_channel_regs #(
	parameter logic [11:0] SUBSYS_CODE = 12'hA5C, // Arbitrary neutral value.
	parameter logic [3:0] TARGET_CODE = 4'h1,
	parameter logic STREAM_IF = 1'b0,
	parameter logic [3:0] CHANNEL_NUM = 4'h0,
	parameter logic [7:0] VERSION_CODE = 8'h3C, // Arbitrary neutral value.
	parameter logic [7:0] ADDR_ALIGN = 8'h01,
	parameter logic [7:0] LEN_GRAN = 8'h01,
	parameter logic [7:0] ADDR_BITS = 8'h40
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Engine side.
	input wire dcc_pkg::dcc_engine_evt_s engine_evt,
	output dcc_pkg::dcc_engine_ctl_s engine_ctl,
	output dcc_pkg::dcc_writeback_s writeback,
	// Interrupt.
	output logic irq
);
	import dcc_pkg::*;

	logic [31:0] ctrl_ff;
	logic [31:0] nxt_ctrl;
	logic [31:0] stat_ff;
	logic [31:0] nxt_stat;
	logic [31:0] mask_ff;
	logic [31:0] wb_lo_ff;
	logic [31:0] wb_hi_ff;
	logic [31:0] done_cnt_ff;
	logic [2:0] pm_ff;
	logic halt_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic [`DCC_CNT_W-1:0] cnt_ff [2];
	logic [1:0] maxed_ff;
	logic [1:0] cnt_inc;
	dcc_run_state_e state_ff;
	dcc_writeback_s wb_ff;
	logic wr;
	logic rd_acc;
	logic setup;
	logic run_rise;
	logic idle_evt;
	logic desc_fault;
	logic read_fault;
	logic pm_clear;
	logic pm_active;
	logic [31:0] stat_evt;
	logic [31:0] ident;
	logic [31:0] rd_mux;
	logic mapped;

	// Zero-wait slave: every access phase completes in one cycle.
	assign pready = 1'b1;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	// Identity fields are constants; reserved bits 14:12 stay zero.
	assign ident = {SUBSYS_CODE, TARGET_CODE, STREAM_IF, 3'h0, CHANNEL_NUM, VERSION_CODE};

	// Next control value from plain, set and clear views; reserved bits never load.
	always_comb
	begin
		nxt_ctrl = ctrl_ff;
		if (wr && paddr == `DCC_OFS_CTRL)
		begin
			nxt_ctrl = pwdata & `DCC_CTRL_WMASK;
		end
		else if (wr && paddr == `DCC_OFS_CTRL_SET)
		begin
			nxt_ctrl = ctrl_ff | (pwdata & `DCC_CTRL_WMASK);
		end
		else if (wr && paddr == `DCC_OFS_CTRL_CLR)
		begin
			nxt_ctrl = ctrl_ff & ~(pwdata & `DCC_CTRL_WMASK);
		end
	end

	assign run_rise = nxt_ctrl[`DCC_BIT_RUN] & ~ctrl_ff[`DCC_BIT_RUN];

	// Control register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff <= `DCC_CTRL_RESET;
		end
		else
		begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// A fault with a fully enabled field holds the engine stopped until run is set again.
	assign desc_fault = (ctrl_ff[`DCC_DESC_ERR_LSB +: 5] == `DCC_ERR_ALL) &&
		(engine_evt.desc_error != 5'h00);
	assign read_fault = (ctrl_ff[`DCC_RD_ERR_LSB +: 5] == `DCC_ERR_ALL) &&
		(engine_evt.read_error != 5'h00);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			halt_ff <= 1'b0;
		end
		else if (desc_fault || read_fault)
		begin
			halt_ff <= 1'b1;
		end
		else if (run_rise)
		begin
			halt_ff <= 1'b0;
		end
	end

	// Tracks a stop request until the engine drains its descriptor and goes idle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= DCC_ST_IDLE;
		end
		else
		begin
			case (state_ff)
				DCC_ST_IDLE:
				begin
					if (ctrl_ff[`DCC_BIT_RUN])
					begin
						state_ff <= DCC_ST_RUN;
					end
				end
				DCC_ST_RUN:
				begin
					if (!ctrl_ff[`DCC_BIT_RUN])
					begin
						state_ff <= DCC_ST_DRAIN;
					end
				end
				DCC_ST_DRAIN:
				begin
					if (ctrl_ff[`DCC_BIT_RUN])
					begin
						state_ff <= DCC_ST_RUN;
					end
					else if (!engine_evt.busy)
					begin
						state_ff <= DCC_ST_IDLE;
					end
				end
				default:
				begin
					state_ff <= DCC_ST_IDLE;
				end
			endcase
		end
	end

	assign idle_evt = (state_ff == DCC_ST_DRAIN) && !ctrl_ff[`DCC_BIT_RUN] && !engine_evt.busy;

	// Raw conditions laid out like the status word, then gated by their enables.
	always_comb
	begin
		stat_evt = 32'h00000000;
		stat_evt[`DCC_DESC_ERR_LSB +: 5] = engine_evt.desc_error;
		stat_evt[`DCC_RD_ERR_LSB +: 5] = engine_evt.read_error;
		stat_evt[`DCC_BIT_IDLE_HALT] = idle_evt;
		stat_evt[`DCC_BIT_BAD_LEN] = engine_evt.bad_length;
		stat_evt[`DCC_BIT_BAD_SIG] = engine_evt.bad_signature;
		stat_evt[`DCC_BIT_MISALIGN] = engine_evt.misalignment;
		stat_evt[`DCC_BIT_DESC_DONE] = engine_evt.desc_done & engine_evt.desc_done_flag;
		stat_evt[`DCC_BIT_DESC_HALT] = engine_evt.desc_done & engine_evt.desc_stop_flag;
		stat_evt = stat_evt & ctrl_ff & `DCC_STAT_WMASK;
	end

	// Clearing by run, W1C or read-to-clear loses to a new event in the same cycle.
	always_comb
	begin
		nxt_stat = stat_ff;
		if (run_rise)
		begin
			nxt_stat = 32'h00000000;
		end
		else if (wr && paddr == `DCC_OFS_STAT)
		begin
			nxt_stat = stat_ff & ~(pwdata & `DCC_STAT_WMASK);
		end
		else if (rd_acc && paddr == `DCC_OFS_STAT_RC)
		begin
			// Only bits already returned clear, so an event logged at the setup edge survives.
			nxt_stat = stat_ff & ~(prdata_ff & `DCC_STAT_WMASK);
		end
		nxt_stat = nxt_stat | stat_evt;
	end

	// Status register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_ff <= `DCC_STAT_RESET;
		end
		else
		begin
			stat_ff <= nxt_stat;
		end
	end

	// Interrupt mask with plain, set and clear views.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask_ff <= `DCC_MASK_RESET;
		end
		else if (wr && paddr == `DCC_OFS_MASK)
		begin
			mask_ff <= pwdata & `DCC_STAT_WMASK;
		end
		else if (wr && paddr == `DCC_OFS_MASK_SET)
		begin
			mask_ff <= mask_ff | (pwdata & `DCC_STAT_WMASK);
		end
		else if (wr && paddr == `DCC_OFS_MASK_CLR)
		begin
			mask_ff <= mask_ff & ~(pwdata & `DCC_STAT_WMASK);
		end
	end

	assign irq = |(stat_ff & mask_ff);

	// Poll-mode writeback address.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wb_lo_ff <= 32'h00000000;
			wb_hi_ff <= 32'h00000000;
		end
		else if (wr && paddr == `DCC_OFS_WB_LO)
		begin
			wb_lo_ff <= pwdata;
		end
		else if (wr && paddr == `DCC_OFS_WB_HI)
		begin
			wb_hi_ff <= pwdata;
		end
	end

	// Completed descriptor count; the run edge wins so a new list starts from zero.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_cnt_ff <= 32'h00000000;
		end
		else if (run_rise)
		begin
			done_cnt_ff <= 32'h00000000;
		end
		else if (engine_evt.desc_done)
		begin
			done_cnt_ff <= done_cnt_ff + 32'h00000001;
		end
	end

	// Writeback request carries the count including the descriptor just completed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wb_ff <= '0;
		end
		else
		begin
			wb_ff.valid <= ctrl_ff[`DCC_BIT_WB_ON] & engine_evt.desc_done &
				engine_evt.desc_done_flag & ~run_rise;
			wb_ff.count <= done_cnt_ff + 32'h00000001;
		end
	end

	assign writeback = wb_ff;

	// Controls to the engine; metadata suppression only exists on a streaming build.
	always_comb
	begin
		engine_ctl.run = ctrl_ff[`DCC_BIT_RUN] & ~halt_ff;
		engine_ctl.fault_halt = halt_ff;
		engine_ctl.meta_writeback_off = ctrl_ff[`DCC_BIT_NO_META] & STREAM_IF;
		engine_ctl.fixed_read_addr = ctrl_ff[`DCC_BIT_NON_INC];
		engine_ctl.completion_writeback_on = ctrl_ff[`DCC_BIT_WB_ON];
		engine_ctl.writeback_addr = {wb_hi_ff, wb_lo_ff};
	end

	// Monitor control; clear is a write-only strobe and never stored.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pm_ff <= 3'h0;
		end
		else if (wr && paddr == `DCC_OFS_PMON)
		begin
			pm_ff <= {pwdata[`DCC_PM_RUN], 1'b0, pwdata[`DCC_PM_AUTO]};
		end
		else if (pm_ff[`DCC_PM_AUTO] && engine_evt.desc_done && engine_evt.desc_stop_flag)
		begin
			pm_ff[`DCC_PM_RUN] <= 1'b0;
		end
	end

	// Counters are only cleared from the monitor control, never by writes to them.
	assign pm_clear = (wr && paddr == `DCC_OFS_PMON && pwdata[`DCC_PM_CLEAR]) ||
		(pm_ff[`DCC_PM_AUTO] && run_rise);
	assign pm_active = pm_ff[`DCC_PM_RUN] & ctrl_ff[`DCC_BIT_RUN];
	assign cnt_inc[0] = pm_active;
	assign cnt_inc[1] = pm_active & engine_evt.read_beat_valid;

	// Index 0 counts cycles, index 1 counts read beats; both saturate at all ones.
	for (genvar i = 0; i < 2; i++)
	begin : g_cnt
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				cnt_ff[i] <= '0;
				maxed_ff[i] <= 1'b0;
			end
			else if (pm_clear)
			begin
				cnt_ff[i] <= '0;
				maxed_ff[i] <= 1'b0;
			end
			else
			begin
				if (cnt_inc[i] && cnt_ff[i] != `DCC_CNT_MAX)
				begin
					cnt_ff[i] <= cnt_ff[i] + 42'h00000000001;
				end
				if (cnt_ff[i] == `DCC_CNT_MAX)
				begin
					maxed_ff[i] <= 1'b1;
				end
			end
		end
	end

	// Read decode; unmapped offsets read zero and flag an error.
	always_comb
	begin
		rd_mux = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			`DCC_OFS_IDENT: rd_mux = ident;
			`DCC_OFS_CTRL: rd_mux = ctrl_ff;
			`DCC_OFS_CTRL_SET: rd_mux = ctrl_ff;
			`DCC_OFS_CTRL_CLR: rd_mux = ctrl_ff;
			`DCC_OFS_STAT: rd_mux = stat_ff | {31'h00000000, engine_evt.busy};
			`DCC_OFS_STAT_RC: rd_mux = stat_ff | {31'h00000000, engine_evt.busy};
			`DCC_OFS_DONE_CNT: rd_mux = done_cnt_ff;
			`DCC_OFS_ALIGN: rd_mux = {8'h00, ADDR_ALIGN, LEN_GRAN, ADDR_BITS};
			`DCC_OFS_WB_LO: rd_mux = wb_lo_ff;
			`DCC_OFS_WB_HI: rd_mux = wb_hi_ff;
			`DCC_OFS_MASK: rd_mux = mask_ff;
			`DCC_OFS_MASK_SET: rd_mux = mask_ff;
			`DCC_OFS_MASK_CLR: rd_mux = mask_ff;
			`DCC_OFS_PMON: rd_mux = {29'h00000000, pm_ff};
			`DCC_OFS_CYC_LO: rd_mux = cnt_ff[0][31:0];
			`DCC_OFS_CYC_HI: rd_mux = {15'h0000, maxed_ff[0], 6'h00, cnt_ff[0][41:32]};
			`DCC_OFS_BEAT_LO: rd_mux = cnt_ff[1][31:0];
			`DCC_OFS_BEAT_HI: rd_mux = {15'h0000, maxed_ff[1], 6'h00, cnt_ff[1][41:32]};
			default: mapped = 1'b0;
		endcase
	end

	// Read data and error are captured in the setup cycle and held through the access.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
		else if (setup)
		begin
			prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
			pslverr_ff <= ~mapped;
		end
		else if (!psel)
		begin
			prdata_ff <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
	end

endmodule

//--- dv/dcc_channel_regs_chk.sv
`timescale 1ns/1ps
module dcc_channel_regs_chk (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB request.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	// Engine side and interrupt.
	input wire dcc_pkg::dcc_engine_evt_s engine_evt,
	input wire dcc_pkg::dcc_engine_ctl_s engine_ctl,
	input wire dcc_pkg::dcc_writeback_s writeback,
	input wire logic irq
);
	import dcc_pkg::*;
	logic acc;
	logic wr;
	logic err;
	logic wbc;
	// Software can only change state in a completed access cycle.
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign err = (|engine_evt.desc_error) || (|engine_evt.read_error);
	assign wbc = engine_evt.desc_done && engine_evt.desc_done_flag && engine_ctl.completion_writeback_on;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_halt_cause;
		$rose(engine_ctl.fault_halt) |-> $past(err);
	endproperty
	a_halt_cause: assert property (p_halt_cause) else $error("halt without an error");
	property p_halt_stops;
		engine_ctl.fault_halt |-> !engine_ctl.run;
	endproperty
	a_halt_stops: assert property (p_halt_stops) else $error("run high while halted");
	property p_halt_hold;
		engine_ctl.fault_halt && !wr |=> engine_ctl.fault_halt;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt dropped by itself");
	property p_run_rise;
		$rose(engine_ctl.run) |-> $past(wr);
	endproperty
	a_run_rise: assert property (p_run_rise) else $error("run rose without a write");
	property p_no_meta;
		!engine_ctl.meta_writeback_off;
	endproperty
	a_no_meta: assert property (p_no_meta) else $error("metadata off on mapped channel");
	property p_ctl_stable;
		!wr |=> $stable({engine_ctl.fixed_read_addr, engine_ctl.completion_writeback_on});
	endproperty
	a_ctl_stable: assert property (p_ctl_stable) else $error("control moved without write");
	property p_wb_cause;
		writeback.valid |-> $past(wbc);
	endproperty
	a_wb_cause: assert property (p_wb_cause) else $error("writeback without cause");
	property p_irq_clear;
		$fell(irq) |-> $past(acc);
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq fell without access");
	c_wb: cover property (writeback.valid);
	c_halt: cover property ($rose(engine_ctl.fault_halt));
	c_irq: cover property ($rose(irq));
endmodule

//--- dv/dcc_channel_regs_tb.sv
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_channel_regs_tb;
	import dcc_pkg::*;
	localparam logic [31:0] IDENT = {12'hA5C, 4'h1, 1'b0, 3'h0, 4'h0, 8'h3C};
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	dcc_engine_evt_s evt;
	dcc_engine_ctl_s engine_ctl;
	dcc_writeback_s writeback;
	int num_errors = 0;
	int tests_run = 0;
	dcc_channel_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .engine_evt(evt), .engine_ctl(engine_ctl), .writeback(writeback),
		.irq(irq));
	// Free-running bus clock.
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input logic [63:0] g, input logic [63:0] x);
		tests_run++;
		if (g !== x)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, x);
		end
	endtask
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk({e, q}, {1'b0, x});
	endtask
	// An event pulse lasts exactly one sampled edge.
	task automatic pulse(input dcc_engine_evt_s e);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
		#1;
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		rdc(8'h00, IDENT);
		rdc(8'h04, 32'h0);
		rdc(8'h90, 32'h0);
		chk(engine_ctl[68:64], 5'h00);
		wr(8'h00, 32'hFFFFFFFF);
		rdc(8'h00, IDENT);
		apb(1'b0, 8'h10, 32'h0, q, e);
		chk({e, q}, 33'h100000000);
	endtask
	task automatic t_ctrl();
		wr(8'h04, 32'hFFFFFFFF);
		rdc(8'h04, `DCC_CTRL_WMASK);
		chk(engine_ctl[68:64], 5'h13);
		wr(8'h0C, 32'hFFFFFFFF);
		rdc(8'h04, 32'h0);
		wr(8'h08, 32'h04000000);
		rdc(8'h04, 32'h04000000);
		wr(8'h88, 32'h89ABCDEF);
		wr(8'h8C, 32'h01234567);
		chk(engine_ctl.writeback_addr, 64'h0123456789ABCDEF);
	endtask
	// Logging needs the enable, the interrupt needs the mask as well.
	task automatic t_log();
		dcc_engine_evt_s e;
		wr(8'h08, 32'h5);
		e = '0;
		e.desc_done = 1'b1;
		e.desc_done_flag = 1'b1;
		pulse(e);
		chk(writeback, {1'b1, 32'h1});
		chk(irq, 1'b0);
		rdc(8'h40, 32'h4);
		wr(8'h94, 32'h7E);
		chk(irq, 1'b1);
		wr(8'h40, 32'h4);
		chk(irq, 1'b0);
		wr(8'h0C, 32'h4);
		pulse(e);
		rdc(8'h40, 32'h0);
		rdc(8'h48, 32'h2);
		for (int k = 1; k < 6; k++)
		begin
			wr(8'h08, 32'h1 << k);
			e = '0;
			e.desc_done = (k < 3);
			e.desc_stop_flag = (k == 1);
			e.desc_done_flag = (k == 2);
			e.misalignment = (k == 3);
			e.bad_signature = (k == 4);
			e.bad_length = (k == 5);
			pulse(e);
			chk(irq, 1'b1);
			rdc(8'h44, 32'h1 << k);
			chk(irq, 1'b0);
			wr(8'h0C, 32'h1 << k);
		end
	endtask
	// A stop while busy waits for the engine to go idle.
	task automatic t_idle();
		wr(8'h08, 32'h40);
		@(posedge pclk);
		evt.busy <= 1'b1;
		wr(8'h0C, 32'h1);
		rdc(8'h40, 32'h1);
		@(posedge pclk);
		evt.busy <= 1'b0;
		repeat (2) @(posedge pclk);
		rdc(8'h40, 32'h40);
		chk(irq, 1'b1);
		wr(8'h08, 32'h1);
		rdc(8'h40, 32'h0);
		rdc(8'h48, 32'h0);
		chk(irq, 1'b0);
	endtask
	// Only a full error enable field halts the engine.
	task automatic t_fault();
		dcc_engine_evt_s e;
		wr(8'h04, 32'h00F80001);
		e = '0;
		e.desc_error = 5'h04;
		pulse(e);
		chk(engine_ctl[68:67], 2'b01);
		rdc(8'h44, 32'h00200000);
		wr(8'h04, 32'h0);
		wr(8'h04, 32'h00000201);
		chk(engine_ctl[68:67], 2'b10);
		e = '0;
		e.read_error = 5'h01;
		pulse(e);
		chk(engine_ctl[68:67], 2'b10);
		rdc(8'h44, 32'h200);
		wr(8'h08, 32'h3E00);
		e.read_error = 5'h02;
		pulse(e);
		chk(engine_ctl[68:67], 2'b01);
		rdc(8'h44, 32'h400);
	endtask
	// Three back-to-back beats; the count words ignore writes.
	task automatic t_perf();
		dcc_engine_evt_s b;
		wr(8'h04, 32'h0);
		wr(8'h04, 32'h1);
		wr(8'hC0, 32'h6);
		@(posedge pclk);
		evt.read_beat_valid <= 1'b1;
		repeat (3) @(posedge pclk);
		evt.read_beat_valid <= 1'b0;
		wr(8'hC0, 32'h0);
		rdc(8'hCC, 32'h3);
		rdc(8'hD0, 32'h0);
		wr(8'hCC, 32'h0);
		wr(8'hD0, 32'h0);
		rdc(8'hCC, 32'h3);
		wr(8'hC0, 32'h2);
		rdc(8'hCC, 32'h0);
		// Auto mode: a stop-flagged descriptor halts counting, the next run edge clears.
		b = '0;
		b.read_beat_valid = 1'b1;
		b.desc_done = 1'b1;
		b.desc_stop_flag = 1'b1;
		wr(8'hC0, 32'h5);
		pulse(b);
		rdc(8'hC0, 32'h1);
		rdc(8'hCC, 32'h1);
		wr(8'h04, 32'h0);
		wr(8'h04, 32'h1);
		rdc(8'hCC, 32'h0);
	endtask
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence after a five-cycle reset.
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		evt = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_log();
		t_idle();
		t_fault();
		t_perf();
		report_and_stop();
	end
	// The tests need well under 2000 cycles.
	initial
	begin
		#200000;
		num_errors++;
		report_and_stop();
	end
endmodule
bind dcc_channel_regs dcc_channel_regs_chk u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.engine_evt(engine_evt),
	.engine_ctl(engine_ctl),
	.writeback(writeback),
	.irq(irq)
);
